// file: include/vds_pkg.sv
package vds_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_D_PAT    = 8'h08;
  localparam logic [7:0] REG_T_PAT    = 8'h0C;
  localparam logic [7:0] REG_P_PAT    = 8'h10;
  localparam logic [7:0] REG_EMUL     = 8'h14;
  localparam logic [7:0] REG_TIMING   = 8'h18;
  localparam logic [7:0] REG_ADDR_A   = 8'h1C;
  localparam logic [7:0] REG_ADDR_B   = 8'h20;
  localparam logic [7:0] REG_MEM_ADDR = 8'h24;
  localparam logic [7:0] REG_MEM_OUT  = 8'h28;
  localparam logic [7:0] REG_MEM_DIR  = 8'h2C;
  localparam logic [7:0] REG_MEM_EN   = 8'h30;
  localparam logic [7:0] REG_MEM_RSP  = 8'h34;
  localparam logic [7:0] REG_CMD      = 8'h38;

  // ==========================================================================
  // control field positions
  localparam int CTRL_TRIG_LINE_LSB = 0;  // 3 bits: backplane trigger line
  localparam int CTRL_PAUSE_LINE_LSB = 3; // 3 bits: backplane pause line
  localparam int CTRL_TRIG_EN_LSB   = 6;  // 5 bits: line, star, ext, sw, event
  localparam int CTRL_PAUSE_EN_LSB  = 11; // 4 bits: line, ext, sw, event
  localparam int CTRL_SEQ_TRIG      = 15; // 1: first then second
  localparam int CTRL_PAUSE_COND    = 16; // 1: pause event needs match
  localparam int CTRL_EMUL_EN       = 17;
  localparam int CTRL_STAR_TRIG     = 18;
  localparam int CTRL_STAR_PAUSE    = 19;
  localparam int CTRL_MODE_LSB      = 20; // 3 bits
  localparam int CTRL_WIDTH_LSB     = 23; // 3 bits: 0=32 .. 5=1
  localparam int CTRL_RUN           = 26;
  localparam int CTRL_CLK_EXT       = 27;
  localparam int CTRL_STB_EXT       = 28;

  // timing register: clock delay [6:0], strobe delay [14:8], divider [31:16]
  localparam int TIM_CLK_DLY_LSB = 0;
  localparam int TIM_STB_DLY_LSB = 8;
  localparam int TIM_DIV_LSB     = 16;
  localparam int DELAY_STEPS_MAX = 108;  // 27 ns in 0.25 ns steps
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] TIMING_RESET = 32'h0003_0000;

  // command bits
  localparam int CMD_SW_TRIG  = 0;
  localparam int CMD_SW_PAUSE = 1;
  localparam int CMD_RESUME   = 2;
  localparam int CMD_STOP     = 3;

  // memory and domain size
  localparam int MEM_AW       = 8;
  localparam int MEM_DEPTH    = 256;
  localparam int CHANNELS     = 32;
  localparam int MAX_SLAVES   = 15;
  localparam int EVENT_W      = 16;
  localparam int LINES        = 8;

  // sequencer modes
  typedef enum logic [2:0] {
    VDS_M_HALT_ADDR  = 3'h0,
    VDS_M_PAUSE_ADDR = 3'h1,
    VDS_M_LOOP_ALL   = 3'h2,
    VDS_M_LOOP_ONE   = 3'h3,
    VDS_M_LOOP_BLOCK = 3'h4
  } vds_mode_t;

  typedef enum logic [4:0] {
    VDS_S_IDLE  = 5'b00001,
    VDS_S_ARMED = 5'b00010,
    VDS_S_RUN   = 5'b00100,
    VDS_S_PAUSE = 5'b01000,
    VDS_S_DONE  = 5'b10000
  } vds_state_t;

endpackage

// file: core/vds_sequencer.sv
// Operation
// - master makes domain timing; a slave never arms, as arming needs the master role, so it never steps on the domain bus line
// - each card has 32 channels; up to 15 slaves, 512 channels in total
// - master or slave role latched from switch once after reset
// - run mode steps vectors without further bus access
// - per-step enable bit; disabled output channel is released to high impedance
// - direction selectable per pin per step
// - master takes a 16-bit external event bus
// - run starts on OR of line, star, external, software and event trigger
// - event match compares pattern, ignoring bits marked in mask
// - two pattern and mask pairs; concurrent or first then second
// - pause on OR of line, star, external, software and event pause
// - event pause unconditional or conditional on pause pattern match
// - host-written emulation word can replace external event lines
// - star trigger usable as trigger, pause, or both
// - clock source internal or external, delay 0 to 27 ns in 0.25 ns steps
// - strobe source internal or external, delay set apart from clock
// - modes: halt at address, pause at address, loop all, one, block
// - all memories cleared to zero after power-up
// - separate drive, response and direction memories; response always captured
// - memory width 32, 16, 8, 4, 2 or 1 channels, each word repeated for 32/width steps
`timescale 1ns/1ns
`default_nettype none
module vds_sequencer (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // board strap and domain bus
  input  wire logic        master_strap,
  input  wire logic [7:0]  bp_trig_in,
  input  wire logic        star_trig,
  input  wire logic        dom_step_in,
  input  wire logic        dom_run_in,
  output logic             dom_step_out,
  output logic             dom_step_oe,
  output logic             dom_run_out,
  output logic             dom_run_oe,
  // timing connector
  input  wire logic        ext_trig,
  input  wire logic        ext_pause,
  input  wire logic [15:0] ext_event,
  input  wire logic        ext_clk,
  input  wire logic        ext_strobe,
  output logic             clk_out,
  output logic [6:0]       clk_delay,
  output logic             strobe_out,
  output logic [6:0]       strobe_delay,
  // unit under test channels
  input  wire logic [31:0] chan_in,
  output logic [31:0]      chan_out,
  output logic [31:0]      chan_oe,
  // status
  output logic             is_master,
  output logic             running
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0]          role_sync;
    logic [1:0]          role_done;
    logic                master;
    logic [1:0][7:0]     bp_s;
    logic [1:0][4:0]     misc_s;
    logic [1:0][15:0]    ev_s;
    logic [1:0][31:0]    ch_s;
    logic                clk_prev;
    logic                stb_prev;
    logic [31:0]         ctrl;
    logic [31:0]         d_pat;
    logic [31:0]         t_pat;
    logic [31:0]         p_pat;
    logic [15:0]         emul;
    logic [31:0]         timing;
    logic [31:0]         addr_a;
    logic [31:0]         addr_b;
    logic [7:0]          mem_addr;
    logic [31:0]         prdata;
    vds_pkg::vds_state_t st;
    logic [7:0]          pc;
    logic [4:0]          sub;
    logic [15:0]         div;
    logic                tick_clk;
    logic [31:0]         chan_out;
    logic [31:0]         chan_oe;
    logic                step_out;
    logic                sw_trig;
    logic                sw_pause;
  } vds_state_s_t;

  vds_state_s_t r;
  vds_state_s_t next_r;

  // each memory is its own array: drive, enable, direction, response
  // power-up clear lives in the initialisers
  logic [31:0] mem_out [vds_pkg::MEM_DEPTH] = '{default: 32'h0000_0000};
  logic [31:0] mem_en  [vds_pkg::MEM_DEPTH] = '{default: 32'h0000_0000};
  logic [31:0] mem_dir [vds_pkg::MEM_DEPTH] = '{default: 32'h0000_0000};
  logic [31:0] mem_rsp [vds_pkg::MEM_DEPTH] = '{default: 32'h0000_0000};

  // ==========================================================================
  // helpers
  function automatic logic ev_match(input logic [15:0] ev, input logic [31:0] pm);
    // low half is pattern, high half is mask (1 = don't care)
    ev_match = &((~(ev ^ pm[15:0])) | pm[31:16]);
  endfunction

  // channels per vector for a width code: 32 >> code
  function automatic logic [5:0] lanes(input logic [2:0] code);
    lanes = (code > 3'h5) ? 6'd32 : 6'(6'd32 >> code);
  endfunction

  logic        apb_wr;
  logic        apb_rd;
  logic [15:0] ev_now;
  logic        m_d;
  logic        m_t;
  logic        m_p;
  logic        trig_any;
  logic        pause_any;
  logic        step_en;
  logic        stb_edge;
  logic [4:0]  ln;
  logic [31:0] lane_mask;
  logic [31:0] wr_data;
  logic [7:0]  cap_addr;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // ==========================================================================
  // next-state logic
  always_comb begin
    next_r = r;
    next_r.sw_trig  = 1'b0;
    next_r.sw_pause = 1'b0;
    next_r.tick_clk = 1'b0;
    next_r.step_out = 1'b0;

    // two-flop synchronisers on every outside input except dom_step_in and the unused dom_run_in
    next_r.role_sync = {r.role_sync[0], master_strap};
    next_r.bp_s      = {r.bp_s[0], bp_trig_in};
    next_r.misc_s    = {r.misc_s[0], {star_trig, ext_trig, ext_pause, ext_clk, ext_strobe}};
    next_r.ev_s      = {r.ev_s[0], ext_event};
    next_r.ch_s      = {r.ch_s[0], chan_in};
    next_r.clk_prev  = r.misc_s[1][1];
    next_r.stb_prev  = r.misc_s[1][0];

    // role caught once after release, never again while running;
    // three edges so the strap has crossed both synchroniser flops
    if (r.role_done != 2'h3) begin
      next_r.master    = r.role_sync[1];
      next_r.role_done = r.role_done + 2'h1;
    end

    // register writes
    if (apb_wr) begin
      unique case (paddr)
        vds_pkg::REG_CTRL:     next_r.ctrl = pwdata;
        vds_pkg::REG_D_PAT:    next_r.d_pat = pwdata;
        vds_pkg::REG_T_PAT:    next_r.t_pat = pwdata;
        vds_pkg::REG_P_PAT:    next_r.p_pat = pwdata;
        vds_pkg::REG_EMUL:     next_r.emul = pwdata[15:0];
        vds_pkg::REG_TIMING:   next_r.timing = pwdata;
        vds_pkg::REG_ADDR_A:   next_r.addr_a = pwdata;
        vds_pkg::REG_ADDR_B:   next_r.addr_b = pwdata;
        vds_pkg::REG_MEM_ADDR: next_r.mem_addr = pwdata[7:0];
        vds_pkg::REG_CMD: begin
          next_r.sw_trig  = pwdata[vds_pkg::CMD_SW_TRIG];
          next_r.sw_pause = pwdata[vds_pkg::CMD_SW_PAUSE];
          if (pwdata[vds_pkg::CMD_RESUME] && r.st == vds_pkg::VDS_S_PAUSE)
            next_r.st = vds_pkg::VDS_S_RUN;
          if (pwdata[vds_pkg::CMD_STOP]) begin
            next_r.st = vds_pkg::VDS_S_IDLE;
            next_r.ctrl[vds_pkg::CTRL_RUN] = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // register reads, latched in the setup cycle
    if (apb_rd) begin
      unique case (paddr)
        vds_pkg::REG_CTRL:     next_r.prdata = r.ctrl;
        vds_pkg::REG_STATUS:   next_r.prdata = {16'h0, 3'h0, r.st, r.pc};
        vds_pkg::REG_D_PAT:    next_r.prdata = r.d_pat;
        vds_pkg::REG_T_PAT:    next_r.prdata = r.t_pat;
        vds_pkg::REG_P_PAT:    next_r.prdata = r.p_pat;
        vds_pkg::REG_EMUL:     next_r.prdata = {16'h0, r.emul};
        vds_pkg::REG_TIMING:   next_r.prdata = r.timing;
        vds_pkg::REG_ADDR_A:   next_r.prdata = r.addr_a;
        vds_pkg::REG_ADDR_B:   next_r.prdata = r.addr_b;
        vds_pkg::REG_MEM_ADDR: next_r.prdata = {24'h0, r.mem_addr};
        vds_pkg::REG_MEM_OUT:  next_r.prdata = mem_out[r.mem_addr];
        vds_pkg::REG_MEM_DIR:  next_r.prdata = mem_dir[r.mem_addr];
        vds_pkg::REG_MEM_EN:   next_r.prdata = mem_en[r.mem_addr];
        vds_pkg::REG_MEM_RSP:  next_r.prdata = mem_rsp[r.mem_addr];
        default:               next_r.prdata = 32'h0000_0000;
      endcase
    end

    // internal clock divider makes the step enable
    if (r.div == 16'h0) begin
      next_r.div      = r.timing[31:16];
      next_r.tick_clk = 1'b1;
    end else begin
      next_r.div = r.div - 16'h1;
    end

    // trigger and pause handling
    unique case (r.st)
      vds_pkg::VDS_S_IDLE: begin
        next_r.pc  = 8'h0;
        next_r.sub = 5'h0;
        if (r.ctrl[vds_pkg::CTRL_RUN] && r.master)
          next_r.st = vds_pkg::VDS_S_ARMED;
      end
      vds_pkg::VDS_S_ARMED: begin
        if (!r.ctrl[vds_pkg::CTRL_RUN])
          next_r.st = vds_pkg::VDS_S_IDLE;
        else if (trig_any)
          next_r.st = vds_pkg::VDS_S_RUN;
      end
      vds_pkg::VDS_S_RUN: begin
        if (!r.ctrl[vds_pkg::CTRL_RUN]) begin
          next_r.st = vds_pkg::VDS_S_IDLE;
        end else if (pause_any) begin
          next_r.st = vds_pkg::VDS_S_PAUSE;
        end else if (step_en) begin  // no bus access needed to step
          // strobe out only on a real step, never idle or paused
          next_r.step_out = 1'b1;
          // advance sub-lane first, then address
          // six bits: a one-lane word has 32 sub-steps
          if (6'(r.sub) + 6'h1 < 6'(vds_pkg::CHANNELS / lanes(r.ctrl[25:23]))) begin
            next_r.sub = r.sub + 5'h1;
          end else begin
            next_r.sub = 5'h0;
            unique case (vds_pkg::vds_mode_t'(r.ctrl[22:20]))
              vds_pkg::VDS_M_HALT_ADDR:
                if (r.pc == r.addr_a[7:0]) next_r.st = vds_pkg::VDS_S_DONE;
                else next_r.pc = r.pc + 8'h1;
              vds_pkg::VDS_M_PAUSE_ADDR:
                if (r.pc == r.addr_a[7:0]) next_r.st = vds_pkg::VDS_S_PAUSE;
                else next_r.pc = r.pc + 8'h1;
              vds_pkg::VDS_M_LOOP_ALL:   next_r.pc = r.pc + 8'h1;
              vds_pkg::VDS_M_LOOP_ONE:   next_r.pc = r.addr_a[7:0];
              vds_pkg::VDS_M_LOOP_BLOCK:
                next_r.pc = (r.pc >= r.addr_b[7:0] || r.pc < r.addr_a[7:0]) ? r.addr_a[7:0] : r.pc + 8'h1;
              default: next_r.st = vds_pkg::VDS_S_DONE;  // illegal mode code
            endcase
          end
          // drive this step: disabled channel released direction per pin
          next_r.chan_out = mem_out[r.pc];
          next_r.chan_oe  = mem_en[r.pc] & mem_dir[r.pc] & lane_mask;
        end
      end
      vds_pkg::VDS_S_PAUSE: begin
        if (!r.ctrl[vds_pkg::CTRL_RUN]) next_r.st = vds_pkg::VDS_S_IDLE;
      end
      vds_pkg::VDS_S_DONE: begin
        next_r.chan_oe = 32'h0;
        if (!r.ctrl[vds_pkg::CTRL_RUN]) next_r.st = vds_pkg::VDS_S_IDLE;
      end
    endcase

    // sequential trigger: first pair arms, second fires
    if (r.st == vds_pkg::VDS_S_ARMED && r.ctrl[vds_pkg::CTRL_SEQ_TRIG] && m_d)
      next_r.d_pat[31] = r.d_pat[31];
  end

  // ==========================================================================
  // event source and matching
  assign ev_now = r.ctrl[vds_pkg::CTRL_EMUL_EN] ? r.emul : r.ev_s[1];
  assign m_d    = ev_match(ev_now, r.d_pat);
  assign m_t    = ev_match(ev_now, r.t_pat);
  assign m_p    = ev_match(ev_now, r.p_pat);

  // ==========================================================================
  // source merge, all OR-ed together
  logic seq_arm;
  logic evt_trig;
  assign evt_trig = r.ctrl[vds_pkg::CTRL_SEQ_TRIG] ? (seq_arm && m_t) : (m_d && m_t);
  assign trig_any =
      (r.ctrl[6]  && r.bp_s[1][r.ctrl[2:0]])
    | (r.ctrl[7]  && r.ctrl[vds_pkg::CTRL_STAR_TRIG] && r.misc_s[1][4])
    | (r.ctrl[8]  && r.misc_s[1][3])
    | (r.ctrl[9]  && r.sw_trig)
    | (r.ctrl[10] && evt_trig);
  assign pause_any =
      (r.ctrl[11] && r.bp_s[1][r.ctrl[5:3]])
    | (r.ctrl[vds_pkg::CTRL_STAR_PAUSE] && r.misc_s[1][4])
    | (r.ctrl[12] && r.misc_s[1][2])
    | (r.ctrl[13] && r.sw_pause)
    | (r.ctrl[14] && (!r.ctrl[vds_pkg::CTRL_PAUSE_COND] || m_p));

  // master steps from its own clock choice; slave follows the domain line
  assign step_en  = r.master ? (r.ctrl[vds_pkg::CTRL_CLK_EXT] ? (r.misc_s[1][1] && !r.clk_prev) : r.tick_clk)
                             : dom_step_in;
  assign stb_edge = r.ctrl[vds_pkg::CTRL_STB_EXT] ? (r.misc_s[1][0] && !r.stb_prev) : step_en;
  assign ln        = 5'(lanes(r.ctrl[25:23]) - 6'd1);
  assign lane_mask = (ln == 5'd31) ? 32'hFFFF_FFFF : ((32'h1 << (ln + 5'd1)) - 32'h1);
  assign cap_addr  = r.pc;
  assign wr_data   = pwdata;

  // arm flag for first-then-second trigger
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_arm <= 1'b0;
    end else if (r.st != vds_pkg::VDS_S_ARMED) begin
      seq_arm <= 1'b0;
    end else if (m_d) begin
      seq_arm <= 1'b1;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r        <= '0;
      r.ctrl   <= vds_pkg::CTRL_RESET;
      r.timing <= vds_pkg::TIMING_RESET;
      r.st     <= vds_pkg::VDS_S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // memories: cleared at power-up, host writes, response always recorded
  // no initial block here: a second writing
  // process would give the arrays two drivers
  always_ff @(posedge mclk) begin
    if (apb_wr && paddr == vds_pkg::REG_MEM_OUT) mem_out[r.mem_addr] <= wr_data;
    if (apb_wr && paddr == vds_pkg::REG_MEM_DIR) mem_dir[r.mem_addr] <= wr_data;
    if (apb_wr && paddr == vds_pkg::REG_MEM_EN)  mem_en[r.mem_addr]  <= wr_data;
    if (r.st == vds_pkg::VDS_S_RUN && stb_edge)
      mem_rsp[cap_addr] <= r.ch_s[1];  // captured whatever the direction
  end

  // ==========================================================================
  // outputs
  assign pready       = 1'b1;
  assign pslverr      = 1'b0;
  assign prdata       = r.prdata;
  assign chan_out     = r.chan_out;  // 32 channels per card
  assign chan_oe      = r.chan_oe;
  assign clk_out      = r.step_out;
  assign strobe_out   = r.step_out;
  assign clk_delay    = (r.timing[6:0] > 7'(vds_pkg::DELAY_STEPS_MAX)) ? 7'(vds_pkg::DELAY_STEPS_MAX)
                                                                       : r.timing[6:0];
  assign strobe_delay = (r.timing[14:8] > 7'(vds_pkg::DELAY_STEPS_MAX)) ? 7'(vds_pkg::DELAY_STEPS_MAX)
                                                                        : r.timing[14:8];
  assign dom_step_out = r.step_out;
  assign dom_step_oe  = r.master;
  assign dom_run_out  = (r.st == vds_pkg::VDS_S_RUN);
  assign dom_run_oe   = r.master;
  assign is_master    = r.master;
  assign running      = (r.st == vds_pkg::VDS_S_RUN);

endmodule
`default_nettype wire

// file: bench/vds_sequencer_props.sv
`timescale 1ns/1ns
`default_nettype none
module vds_sequencer_props (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // watched outputs
  input wire logic        dom_step_out,
  input wire logic        dom_step_oe,
  input wire logic        dom_run_oe,
  input wire logic        clk_out,
  input wire logic [6:0]  clk_delay,
  input wire logic [6:0]  strobe_delay,
  input wire logic [31:0] chan_out,
  input wire logic [31:0] chan_oe,
  input wire logic        is_master,
  input wire logic        running
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // edges since reset, saturating; the role may settle late by three edges
  logic [2:0] age;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end

  // ==========================================================================
  // assertions
  a_step_oe_role: assert property (dom_step_oe |-> is_master)
    else $error("step line driven by a slave");
  a_run_oe_role: assert property (dom_run_oe |-> is_master)
    else $error("run line driven by a slave");
  a_role_fixed: assert property (age >= 3'h4 |-> $stable(is_master))
    else $error("role changed while running");
  a_clk_dly_max: assert property (clk_delay <= 7'h6C)
    else $error("clock delay above 27 ns");
  a_stb_dly_max: assert property (strobe_delay <= 7'h6C)
    else $error("strobe delay above 27 ns");
  a_step_in_run: assert property (dom_step_out |-> running || $past(running))
    else $error("step pulse outside a run");
  a_clk_in_run: assert property (clk_out |-> running || $past(running))
    else $error("domain clock pulse outside a run");
  a_idle_hold: assert property (!running && !$past(running) && !$past(running, 2)
    |-> $stable(chan_out) && $stable(chan_oe))
    else $error("channels moved while idle");

  // main scenarios reached
  c_run: cover property ($rose(running));
  c_step: cover property (clk_out ##1 !clk_out);
  c_master: cover property (is_master && dom_step_oe);
endmodule

bind vds_sequencer vds_sequencer_props i_props (
  .mclk        (mclk),
  .rst         (rst),
  .dom_step_out(dom_step_out),
  .dom_step_oe (dom_step_oe),
  .dom_run_oe  (dom_run_oe),
  .clk_out     (clk_out),
  .clk_delay   (clk_delay),
  .strobe_delay(strobe_delay),
  .chan_out    (chan_out),
  .chan_oe     (chan_oe),
  .is_master   (is_master),
  .running     (running)
);
`default_nettype wire

// file: bench/vds_uut_model.sv
`timescale 1ns/1ns
`default_nettype none
module vds_uut_model (
  // domain clock and channels
  input  wire logic        mclk,
  input  wire logic [31:0] chan_out,
  input  wire logic [31:0] chan_oe,
  // answers toward the card
  output logic [31:0]      chan_in,
  output logic             ext_clk,
  output logic             ext_strobe
);
  logic [31:0] noise;

  // unit clock, phase unrelated to mclk; timing only via the master
  initial begin
    ext_clk = 1'b0;
    #37;
    forever #200 ext_clk = ~ext_clk;
  end
  always @(ext_clk) ext_strobe <= #60 ext_clk;

  // released lines show a changing pattern, never the last value
  initial noise = 32'h5A5A_5A5A;
  always @(posedge mclk) noise <= ~noise;
  assign chan_in = (chan_out & chan_oe) | (noise & ~chan_oe);
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ==========================================================================
  // signals
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        master_strap = 1'b1;
  logic [2:0]  pins = 3'h0;
  logic [7:0]  bp = 8'h00;
  logic [15:0] ext_event = 16'h0000;
  logic        pready, pslverr, dom_step_out, dom_step_oe, dom_run_out, dom_run_oe;
  logic        clk_out, strobe_out, ext_clk, ext_strobe, is_master, running;
  logic [6:0]  clk_delay, strobe_delay;
  logic [31:0] prdata, chan_in, chan_out, chan_oe, rd_data;
  int          n_tests = 0;
  int          n_mismatch = 0;

  always #25 mclk = ~mclk;

  vds_sequencer i_vds_sequencer (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .master_strap(master_strap), .bp_trig_in(bp), .star_trig(pins[2]),
    .dom_step_in(1'b0), .dom_run_in(1'b0), .dom_step_out(dom_step_out),
    .dom_step_oe(dom_step_oe), .dom_run_out(dom_run_out), .dom_run_oe(dom_run_oe),
    .ext_trig(pins[0]), .ext_pause(pins[1]), .ext_event(ext_event), .ext_clk(ext_clk),
    .ext_strobe(ext_strobe), .clk_out(clk_out), .clk_delay(clk_delay),
    .strobe_out(strobe_out), .strobe_delay(strobe_delay), .chan_in(chan_in),
    .chan_out(chan_out), .chan_oe(chan_oe), .is_master(is_master), .running(running));

  vds_uut_model i_vds_uut_model (.mclk(mclk), .chan_out(chan_out), .chan_oe(chan_oe),
    .chan_in(chan_in), .ext_clk(ext_clk), .ext_strobe(ext_strobe));

  // ==========================================================================
  // apb cycle, entered just after a rising edge; one idle edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) n_mismatch++;
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd_data, e);
  endtask

  // poll the state field of the status word, bounded
  task automatic wait_state(input logic [4:0] st);
    int n;
    n = 0;
    apb(1'b0, vds_pkg::REG_STATUS, 32'h0000_0000);
    while (rd_data[12:8] !== st && n < 60) begin
      apb(1'b0, vds_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end
    check({27'h0, rd_data[12:8]}, {27'h0, st});
  endtask

  // stop, set control, then raise run so arming sees a fresh request
  task automatic arm(input logic [31:0] c);
    wr(vds_pkg::REG_CMD, 32'h0000_0008);
    wr(vds_pkg::REG_CTRL, c);
    wr(vds_pkg::REG_CTRL, c | 32'h0400_0000);
  endtask

  // pins held four edges so the two-flop synchroniser sees them
  task automatic pulse(input int b);
    pins[b] <= 1'b1;
    repeat (4) @(posedge mclk);
    pins[b] <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic load(input logic [7:0] a, input logic [31:0] o, input logic [31:0] d,
                      input logic [31:0] e);
    wr(vds_pkg::REG_MEM_ADDR, {24'h00, a});
    wr(vds_pkg::REG_MEM_OUT, o);
    wr(vds_pkg::REG_MEM_DIR, d);
    wr(vds_pkg::REG_MEM_EN, e);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the sequence needs well under 10000 edges
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    master_strap <= 1'b0;
    check({31'h0, is_master}, 32'h0000_0001);
    check({31'h0, dom_run_oe}, 32'h0000_0001);
    rd_chk(vds_pkg::REG_CTRL, vds_pkg::CTRL_RESET);
    rd_chk(vds_pkg::REG_TIMING, vds_pkg::TIMING_RESET);
    rd_chk(8'h3C, 32'h0000_0000);
    wr(vds_pkg::REG_MEM_ADDR, 32'h0000_0005);
    rd_chk(vds_pkg::REG_MEM_OUT, 32'h0000_0000);
    rd_chk(vds_pkg::REG_MEM_DIR, 32'h0000_0000);
    rd_chk(vds_pkg::REG_MEM_RSP, 32'h0000_0000);
    wr(vds_pkg::REG_TIMING, 32'h0003_7F1B);
    repeat (2) @(posedge mclk);
    check({25'h0, clk_delay}, 32'h0000_001B);
    check({25'h0, strobe_delay}, 32'h0000_006C);
    load(8'h00, 32'hA5A5_A5A5, 32'hFFFF_FFFF, 32'h0000_FFFF);
    load(8'h01, 32'h3C3C_3C3C, 32'hFFFF_00FF, 32'h00FF_FFFF);
    wr(vds_pkg::REG_ADDR_A, 32'h0000_0001);
    // pause at address, then halt at address on internal and external clock
    arm(32'h0010_0200);
    wr(vds_pkg::REG_CMD, 32'h0000_0001);
    wait_state(vds_pkg::VDS_S_PAUSE);
    check(chan_oe, 32'h00FF_00FF);
    for (int k = 0; k < 2; k++) begin
      arm(k == 0 ? 32'h0000_0200 : 32'h0800_0200);
      wr(vds_pkg::REG_CMD, 32'h0000_0001);
      wait_state(vds_pkg::VDS_S_RUN);
      repeat (120) @(posedge mclk);
      check({31'h0, running}, 32'h0000_0000);
      check(chan_out, 32'h3C3C_3C3C);
      check(chan_oe, 32'h0000_0000);
    end
    // masked event match on the pins, then the emulation word
    wr(vds_pkg::REG_T_PAT, 32'hFFFF_0000);
    wr(vds_pkg::REG_D_PAT, 32'h00FF_1234);
    arm(32'h0020_0400);
    ext_event <= 16'h1334;
    repeat (8) @(posedge mclk);
    wait_state(vds_pkg::VDS_S_ARMED);
    ext_event <= 16'h12C3;
    wait_state(vds_pkg::VDS_S_RUN);
    wr(vds_pkg::REG_EMUL, 32'h0000_0000);
    arm(32'h0022_0400);
    wait_state(vds_pkg::VDS_S_ARMED);
    wr(vds_pkg::REG_EMUL, 32'h0000_1200);
    wait_state(vds_pkg::VDS_S_RUN);
    // first then second pattern
    wr(vds_pkg::REG_T_PAT, 32'h0000_BEEF);
    arm(32'h0022_8400);
    wait_state(vds_pkg::VDS_S_ARMED);
    wr(vds_pkg::REG_EMUL, 32'h0000_BEEF);
    wait_state(vds_pkg::VDS_S_RUN);
    // external trigger and pause, software pause and resume
    arm(32'h0020_3100);
    pulse(0);
    wait_state(vds_pkg::VDS_S_RUN);
    pulse(1);
    wait_state(vds_pkg::VDS_S_PAUSE);
    wr(vds_pkg::REG_CMD, 32'h0000_0004);
    wait_state(vds_pkg::VDS_S_RUN);
    wr(vds_pkg::REG_CMD, 32'h0000_0002);
    wait_state(vds_pkg::VDS_S_PAUSE);
    // backplane line five as trigger
    arm(32'h0020_0045);
    bp[5] <= 1'b1;
    wait_state(vds_pkg::VDS_S_RUN);
    bp[5] <= 1'b0;
    // star line as trigger, then as pause
    arm(32'h0024_0080);
    pulse(2);
    wait_state(vds_pkg::VDS_S_RUN);
    arm(32'h0028_0200);
    wr(vds_pkg::REG_CMD, 32'h0000_0001);
    wait_state(vds_pkg::VDS_S_RUN);
    pulse(2);
    wait_state(vds_pkg::VDS_S_PAUSE);
    check({31'h0, is_master}, 32'h0000_0001);
    give_verdict();
  end
endmodule
`default_nettype wire
